/* File: sideband_ctrl.v */
// sideband control: management interrupt, clock halt, sleep, test port
// assumes a core that saves state and exits its handler on handshakes,
// and a bus unit that runs one acknowledge transaction per request
//
// Overview of operation
// - management interrupt pin is asynchronous and accepted at any time after the reset release window
// - accepted interrupt saves execution state, then enters handler mode
// - in handler mode, issue acknowledge transaction before handler runs
// - interrupt low during reset release floats the bus and TDO output pins
// - halt request enters grant state and issues a grant acknowledge
// - grant state gates core clocks, keeps bus and interrupt units
// - grant state keeps bus snooping and interrupt servicing alive
// - halt release restarts the core clock and resumes execution; in sleep it waits for sleep release
// - halt request never touches the bus clock; it is asynchronous
// - test port shifts data in on TDI and out on TDO by TCK
// - sleep request in grant enters sleep; release returns to grant
`timescale 1ns/1ns
`default_nettype none
`include "sideband_defines.vh"

module sideband_ctrl (
  // clock and reset
  input  wire clk,
  input  wire nrst,
  // asynchronous sideband pins
  input  wire mgmt_irq_n,
  input  wire clock_halt_req_n,
  input  wire sleep_req_n,
  // core handshakes
  input  wire save_done,
  input  wire handler_exit,
  output reg  save_req,
  output reg  privileged_handler_mode,
  output reg  exec_en,
  // clock gates
  output reg  core_clk_en,
  output reg  bus_unit_clk_en,
  output reg  irq_ctl_clk_en,
  output reg  snoop_en,
  output reg  irq_service_en,
  output reg  sleep_state,
  // acknowledge transaction to the host_system_bus unit
  input  wire bus_done,
  output reg  bus_req,
  output reg  bus_cmd,
  output wire bus_oe,
  // test access port
  input  wire tck,
  input  wire tdi,
  output reg  tdo,
  output wire tdo_oe
);

  // ***************************************************************
  // state codes
  // ***************************************************************
  localparam [`SB_STATE_W-1:0] S_RUN     = 7'h01;
  localparam [`SB_STATE_W-1:0] S_SAVE    = 7'h02;
  localparam [`SB_STATE_W-1:0] S_IRQ_ACK = 7'h04;
  localparam [`SB_STATE_W-1:0] S_HANDLER = 7'h08;
  localparam [`SB_STATE_W-1:0] S_HLT_ACK = 7'h10;
  localparam [`SB_STATE_W-1:0] S_GRANT   = 7'h20;
  localparam [`SB_STATE_W-1:0] S_SLEEP   = 7'h40;

  // ***************************************************************
  // input synchronisation
  // ***************************************************************
  wire [`SB_SYNC_WIDTH-1:0] sync;
  wire                      irq_low;
  wire                      halt_low;
  wire                      sleep_low;
  wire                      tck_s;
  wire                      tdi_s;

  sb_sync u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({tdi, tck, sleep_req_n, clock_halt_req_n, mgmt_irq_n}),
    .sync_out (sync)
  );

  assign irq_low   = ~sync[`SB_BIT_IRQ];
  assign halt_low  = ~sync[`SB_BIT_HALT];
  assign sleep_low = ~sync[`SB_BIT_SLEEP];
  assign tck_s     = sync[`SB_BIT_TCK];
  assign tdi_s     = sync[`SB_BIT_TDI];

  // ***************************************************************
  // reset release window and output float
  // ***************************************************************
  reg [2:0] rel_cnt;   // cycles since reset release
  reg       in_win;    // still inside the release window
  reg       float_out; // sticky until the next reset

  // float on interrupt at release
  // the window covers the synchroniser delay, so a pin low at release
  // is still seen; the fsm waits for the window to close
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rel_cnt   <= 3'h0;
      in_win    <= 1'b1;
      float_out <= 1'b0;
    end else begin
      if (in_win) begin
        rel_cnt <= rel_cnt + 3'h1;
        if (rel_cnt == `SB_REL_WIN - 3'h1)
          in_win <= 1'b0;
        if (irq_low)
          float_out <= 1'b1;
      end
    end
  end

  assign bus_oe = ~float_out;
  assign tdo_oe = ~float_out;

  // ***************************************************************
  // management interrupt capture
  // ***************************************************************
  reg irq_low_d;   // previous synchronised level
  reg irq_pend;    // accepted but not yet serviced
  wire irq_fall;
  wire irq_take;

  assign irq_fall = irq_low & ~irq_low_d;

  // falling edge latched; a new edge wins over the clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_low_d <= 1'b0;
      irq_pend  <= 1'b0;
    end else begin
      irq_low_d <= irq_low;
      if (irq_fall && !in_win)
        irq_pend <= 1'b1;
      else if (irq_take)
        irq_pend <= 1'b0;
    end
  end

  // ***************************************************************
  // power and handler state machine
  // ***************************************************************
  reg [`SB_STATE_W-1:0] state;
  reg [`SB_STATE_W-1:0] next_state;

  assign irq_take = state[0] & irq_pend & ~in_win & ~float_out;

  // next state; the interrupt has priority over the halt request
  always @* begin
    next_state = state;
    case (state)
      S_RUN: begin
        if (in_win || float_out)
          next_state = S_RUN;
        else if (irq_pend)
          next_state = S_SAVE;
        else if (halt_low)
          next_state = S_HLT_ACK;
      end
      S_SAVE: begin
        if (save_done)
          next_state = S_IRQ_ACK;
      end
      S_IRQ_ACK: begin
        if (bus_done)
          next_state = S_HANDLER;
      end
      S_HANDLER: begin
        if (handler_exit)
          next_state = S_RUN;
      end
      S_HLT_ACK: begin
        if (bus_done)
          next_state = S_GRANT;
      end
      S_GRANT: begin
        if (!halt_low)
          next_state = S_RUN;
        else if (sleep_low)
          next_state = S_SLEEP;
      end
      S_SLEEP: begin
        if (!sleep_low)
          next_state = S_GRANT;
      end
      default: begin
        next_state = S_RUN;
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      state <= S_RUN;
    else
      state <= next_state;
  end

  // ***************************************************************
  // registered outputs, decoded from the next state
  // ***************************************************************
  wire core_on;
  wire awake;

  assign core_on = ~(next_state[5] | next_state[6]);
  assign awake   = ~next_state[6];

  // outputs settle with the state they belong to
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      save_req                <= 1'b0;
      privileged_handler_mode <= 1'b0;
      exec_en                 <= 1'b0;
      core_clk_en             <= 1'b1;
      bus_unit_clk_en         <= 1'b1;
      irq_ctl_clk_en          <= 1'b1;
      snoop_en                <= 1'b1;
      irq_service_en          <= 1'b1;
      sleep_state             <= 1'b0;
      bus_req                 <= 1'b0;
      bus_cmd                 <= `SB_ACK_MGMT;
    end else begin
      save_req                <= next_state[1];
      privileged_handler_mode <= next_state[2] | next_state[3];
      exec_en                 <= (next_state[0] & ~in_win & ~float_out)
                                 | next_state[3];
      core_clk_en             <= core_on;
      // bus and interrupt units stay clocked except in sleep
      bus_unit_clk_en         <= awake;
      irq_ctl_clk_en          <= awake;
      snoop_en                <= awake;
      irq_service_en          <= awake;
      sleep_state             <= next_state[6];
      bus_req                 <= (next_state[2] | next_state[4])
                                 & ~bus_done;
      if (next_state[4])
        bus_cmd <= `SB_ACK_HALT;
      else if (next_state[2])
        bus_cmd <= `SB_ACK_MGMT;
    end
  end
  // bus clock untouched
  // the halt path only gates enables; clk itself is never gated here

  // ***************************************************************
  // test access port shift path
  // ***************************************************************
  reg tck_d;   // previous test clock level
  reg tdi_cap; // data taken on the rising test clock

  // shift in on rise, out on fall
  // one-bit bypass path; tck must be well below clk/4 to be seen
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tck_d   <= 1'b0;
      tdi_cap <= 1'b0;
      tdo     <= 1'b0;
    end else begin
      tck_d <= tck_s;
      if (tck_s && !tck_d)
        tdi_cap <= tdi_s;
      if (!tck_s && tck_d)
        tdo <= tdi_cap;
    end
  end

endmodule
`default_nettype wire

/* File: sideband_defines.vh */
// constants for the sideband control block
// assumes inclusion by bare name from every design file that needs it
`ifndef SIDEBAND_DEFINES_VH
`define SIDEBAND_DEFINES_VH

// synchroniser depth and input bit positions
`define SB_SYNC_STAGES   2
`define SB_SYNC_WIDTH    5
`define SB_BIT_IRQ       0
`define SB_BIT_HALT      1
`define SB_BIT_SLEEP     2
`define SB_BIT_TCK       3
`define SB_BIT_TDI       4
// reset value of the synchroniser: active-low requests idle high
`define SB_SYNC_RESET    5'h07

// acknowledge transaction codes on the bus command output
`define SB_ACK_MGMT      1'h0
`define SB_ACK_HALT      1'h1

// cycles after reset release in which a low interrupt floats the pins
`define SB_REL_WIN       3'h4

// one-hot state width
`define SB_STATE_W       7

`endif

/* File: sb_sync.v */
// multi-stage synchroniser for a vector of asynchronous pins
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
`include "sideband_defines.vh"

module sb_sync (
  // clock and reset
  input  wire                      clk,
  input  wire                      nrst,
  // asynchronous pins and their synchronised copies
  input  wire [`SB_SYNC_WIDTH-1:0] async_in,
  output reg  [`SB_SYNC_WIDTH-1:0] sync_out
);

  reg [`SB_SYNC_WIDTH-1:0] meta;  // first stage, read only by sync_out

  // two flops per bit; first stage feeds nothing else
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta     <= `SB_SYNC_RESET;
      sync_out <= `SB_SYNC_RESET;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

/* File: chipset_model.sv */
// model of the core and bus unit that answer the block's handshakes
// assumes one clock; lat sets how many cycles each answer waits
`timescale 1ns/1ns
`default_nettype none

module chipset_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // answer delay in cycles
  input  wire logic [2:0] lat,
  // handshakes from the block
  input  wire logic       save_req,
  input  wire logic       bus_req,
  output var  logic       save_done,
  output var  logic       bus_done
);
  logic [2:0] cnt;

  // one-cycle done pulse after lat cycles of a standing request;
  // cleared at once so the next request is never answered early
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 3'h0;
      save_done <= 1'b0;
      bus_done <= 1'b0;
    end else begin
      save_done <= 1'b0;
      bus_done <= 1'b0;
      cnt <= 3'h0;
      if ((save_req || bus_req) && !save_done && !bus_done) begin
        if (cnt == lat) begin
          save_done <= save_req;
          bus_done <= bus_req && !save_req;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: sideband_ctrl_asserts.sv */
// timing checks on the sideband control ports
// assumes binding into sideband_ctrl, one clock, active-low reset
`timescale 1ns/1ns
`default_nettype none
`include "sideband_defines.vh"

module sideband_ctrl_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous pins
  input wire logic mgmt_irq_n,
  input wire logic clock_halt_req_n,
  input wire logic sleep_req_n,
  // core state and clock gates
  input wire logic save_req,
  input wire logic privileged_handler_mode,
  input wire logic exec_en,
  input wire logic core_clk_en,
  input wire logic bus_unit_clk_en,
  input wire logic irq_ctl_clk_en,
  input wire logic snoop_en,
  input wire logic irq_service_en,
  input wire logic sleep_state,
  // acknowledge bus and pin drivers
  input wire logic bus_done,
  input wire logic bus_req,
  input wire logic bus_cmd,
  input wire logic bus_oe,
  input wire logic tdo_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // grant: core stopped but not asleep
  sequence in_grant;
    !core_clk_en && !sleep_state;
  endsequence
  sequence leave_grant;
    in_grant ##0 sleep_req_n && $rose(clock_halt_req_n);
  endsequence
  sequence go_sleep;
    in_grant ##0 !clock_halt_req_n && $fell(sleep_req_n);
  endsequence

  chk_irq_synced: assert property (
    exec_en && core_clk_en && !bus_req && !privileged_handler_mode &&
    $fell(mgmt_irq_n) |=> (!save_req)[*2] ##[1:6] save_req)
    else $error("interrupt not taken in time");
  chk_save_first: assert property (
    $rose(privileged_handler_mode) |-> $past(save_req) && !exec_en)
    else $error("handler entered without save");
  chk_ack_blocks: assert property (
    bus_req |-> !exec_en) else $error("execution during acknowledge");
  chk_ack_code: assert property (
    $rose(bus_req) |-> bus_cmd == (privileged_handler_mode ?
    `SB_ACK_MGMT : `SB_ACK_HALT)) else $error("wrong acknowledge code");
  chk_grant_entry: assert property (
    bus_req && bus_done && bus_cmd |=> !core_clk_en && !bus_req)
    else $error("grant not entered after ack");
  chk_grant_units: assert property (
    in_grant |-> bus_unit_clk_en && irq_ctl_clk_en && snoop_en &&
    irq_service_en && !exec_en) else $error("grant gating wrong");
  chk_halt_release: assert property (
    leave_grant |-> ##[2:6] core_clk_en)
    else $error("clocks not restarted");
  chk_sleep_entry: assert property (
    go_sleep |-> ##[2:6] sleep_state && !bus_unit_clk_en && !snoop_en)
    else $error("sleep not entered");
  chk_float_hold: assert property (
    !bus_oe |=> !bus_oe && tdo_oe == bus_oe)
    else $error("float not held");
endmodule

bind sideband_ctrl sideband_ctrl_asserts i_chk (.clk, .nrst, .mgmt_irq_n,
  .clock_halt_req_n, .sleep_req_n, .save_req, .privileged_handler_mode,
  .exec_en, .core_clk_en, .bus_unit_clk_en, .irq_ctl_clk_en, .snoop_en,
  .irq_service_en, .sleep_state, .bus_done, .bus_req, .bus_cmd, .bus_oe,
  .tdo_oe);

`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the sideband control block
// assumes sideband_ctrl and chipset_model, one 50 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "sideband_defines.vh"

module testbench;
  logic clk, nrst, mgmt_irq_n, clock_halt_req_n, sleep_req_n, tck, tdi;
  logic save_done, handler_exit, bus_done, save_req, exec_en, bus_req;
  logic privileged_handler_mode, core_clk_en, bus_unit_clk_en, tdo;
  logic irq_ctl_clk_en, snoop_en, irq_service_en, sleep_state, bus_cmd;
  logic bus_oe, tdo_oe, b;
  logic [2:0] lat;
  int errors, n_checks, k;

  sideband_ctrl i_sideband_ctrl (.clk, .nrst, .mgmt_irq_n,
    .clock_halt_req_n, .sleep_req_n, .save_done, .handler_exit,
    .save_req, .privileged_handler_mode, .exec_en, .core_clk_en,
    .bus_unit_clk_en, .irq_ctl_clk_en, .snoop_en, .irq_service_en,
    .sleep_state, .bus_done, .bus_req, .bus_cmd, .bus_oe, .tck, .tdi,
    .tdo, .tdo_oe);
  chipset_model i_chipset_model (.clk, .nrst, .lat, .save_req, .bus_req,
    .save_done, .bus_done);

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t saw %b expected %b", $time, seen, exp);
    end
  endtask

  // selectable output for the bounded wait
  function automatic logic pick(input int s);
    case (s)
      0: pick = save_req;
      1: pick = bus_req;
      2: pick = exec_en;
      3: pick = core_clk_en;
      4: pick = sleep_state;
      default: pick = privileged_handler_mode;
    endcase
  endfunction

  // units outside the core stop only in sleep
  function automatic logic exp_unit_on(input logic asleep);
    exp_unit_on = ~asleep;
  endfunction

  // sample on falling edges so registered outputs have settled
  task automatic wait_on(input int s, input logic v);
    int i;
    for (i = 0; i < 60 && pick(s) !== v; i++) @(negedge clk);
    if (i == 60) begin
      errors++;
      end_sim();
    end
  endtask

  // interrupt round trip once the request is standing
  task automatic irq_tail();
    wait_on(0, 1);
    check(exec_en, 1'b0);
    @(posedge clk);
    mgmt_irq_n <= 1'b1;
    wait_on(1, 1);
    check(bus_cmd, `SB_ACK_MGMT);
    check(privileged_handler_mode, 1'b1);
    wait_on(1, 0);
    wait_on(2, 1);
    @(posedge clk);
    handler_exit <= 1'b1;
    @(posedge clk);
    handler_exit <= 1'b0;
    wait_on(5, 0);
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {mgmt_irq_n, clock_halt_req_n, sleep_req_n} = 3'h7;
    {nrst, tck, tdi, handler_exit, b} = 5'h00;
    lat = 3'h0;
    errors = 0;
    n_checks = 0;
    k = $urandom(32'hEC7A5B01);
    repeat (5) @(posedge clk);
    check(exec_en, 1'b0);
    nrst <= 1'b1;
    wait_on(2, 1);
    check(bus_oe & tdo_oe, 1'b1);
    // interrupts, fastest partner first, then random answer delays
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      lat <= (k == 0) ? 3'h0 : 3'($urandom);
      mgmt_irq_n <= 1'b0;
      irq_tail();
    end
    // halt, interrupt deferred in grant, sleep and back
    @(posedge clk);
    clock_halt_req_n <= 1'b0;
    wait_on(1, 1);
    check(bus_cmd, `SB_ACK_HALT);
    wait_on(3, 0);
    check(bus_unit_clk_en & irq_ctl_clk_en, exp_unit_on(1'b0));
    check(snoop_en & irq_service_en, exp_unit_on(1'b0));
    @(posedge clk);
    mgmt_irq_n <= 1'b0;
    sleep_req_n <= 1'b0;
    wait_on(4, 1);
    check(bus_unit_clk_en | snoop_en, exp_unit_on(1'b1));
    @(posedge clk);
    sleep_req_n <= 1'b1;
    wait_on(4, 0);
    check(core_clk_en, 1'b0);
    @(posedge clk);
    clock_halt_req_n <= 1'b1;
    wait_on(3, 1);
    check(bus_unit_clk_en, exp_unit_on(1'b0));
    irq_tail();
    // interrupt pin one cycle before halt, so both are seen in the same cycle: the interrupt goes first
    @(posedge clk);
    mgmt_irq_n <= 1'b0;
    @(posedge clk);
    clock_halt_req_n <= 1'b0;
    wait_on(0, 1);
    check(bus_req, 1'b0);
    irq_tail();
    wait_on(3, 0);
    check(bus_cmd, `SB_ACK_HALT);
    @(posedge clk);
    clock_halt_req_n <= 1'b1;
    wait_on(3, 1);
    check(exec_en, 1'b1);
    // one-bit test path with random data, tck high for 4 clocks in a 13-clock period
    for (k = 0; k < 8; k++) begin
      b = (k == 0) ? 1'b1 : 1'($urandom);
      @(posedge clk);
      tdi <= b;
      repeat (4) @(posedge clk);
      tck <= 1'b1;
      repeat (4) @(posedge clk);
      tck <= 1'b0;
      repeat (5) @(negedge clk);
      check(tdo, b);
    end
    // interrupt low across reset release floats the pins
    @(posedge clk);
    nrst <= 1'b0;
    mgmt_irq_n <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(negedge clk);
    check(bus_oe, 1'b0);
    check(tdo_oe, 1'b0);
    end_sim();
  end
endmodule

`default_nettype wire
